//--- core/sar_conv_regs.svh
// Register offsets, field positions and timing constants of the converter
`ifndef SAR_CONV_REGS_SVH
`define SAR_CONV_REGS_SVH

`define CTRL_OFFSET 5'h00
`define STAT_OFFSET 5'h04
`define RESULT_OFFSET 5'h08
`define IRQ_STAT_OFFSET 5'h0C
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CTRL_BC_BIT 0
`define CTRL_BIP_BIT 1
`define CTRL_RESET 2'b01
`define STAT_VALID_N_BIT 0
`define STAT_OE_BIT 1
`define STAT_BUSY_BIT 2
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1
`define IRQ_MASK_OFFSET 5'h10
`define CLK_PERIOD_NS 8
`define OE_DELAY_NS 500
`define BLANK_DELAY_NS 1500
`define MIN_PULSE_NS 2000
`define STEP_NS 4000
`define OE_CYCLES (`OE_DELAY_NS / `CLK_PERIOD_NS)
`define BLANK_CYCLES (`BLANK_DELAY_NS / `CLK_PERIOD_NS)
`define PULSE_CYCLES \
  ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CYCLES (`STEP_NS / `CLK_PERIOD_NS)
`define MID_CODE 10'h200

`endif

//--- core/sar_conv_pkg.sv
// Types shared by the converter control block
package sar_conv_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DONE = 4'b1000
  } conv_state_e;

  typedef struct packed {
    logic [9:0] data;
    logic data_oe;
    logic result_valid_n;
  } result_bus_s;

  typedef struct packed {
    logic [4:0] awaddr;
    logic aw_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_state_s;
endpackage : sar_conv_pkg

//--- core/sar_adc_convert_control.sv
// Successive-approximation conversion control with AXI4-Lite registers
// Functional notes
// R1 - Standby high: outputs released, completion high
// R2 - Falling start begins conversion, outputs unchanged
// R3 - Completion low, data driven within 500 ns
// R4 - About 1.5 us after rise: release all
// R5 - Controller holds start high at least 2 us
// R6 - Rise mid-conversion aborts, outputs unchanged
// R7 - Pulse of 2 us mid-conversion restarts
// R8 - Bipolar select grounded: straight binary result
// R9 - Bipolar select open: offset binary coding
// R10 - Convert-pulse mode: start low, positive pulses
// R11 - Multiplexed mode: one start low at once
// R12 - Shared bus: blank previous within 15 us
// R13 - Test bits MSB to LSB, keep if below
// R14 - Result held while start stays low
// R15 - Delays and widths counted in clock cycles
// R16 - Comparator input sampled once per step
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "sar_conv_regs.svh"

// Two-flop synchroniser for an input from outside the clock domain
module bit_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous input and its synchronised copy
  input wire logic din,
  output logic dout
);
  logic [1:0] s_q;
  logic [1:0] s_d;

  always_comb begin
    s_d = {s_q[0], din};
  end

  // Only the second stage leaves the module
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= 2'b00;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q[1];
endmodule : bit_sync

module sar_adc_convert_control #(
  parameter int WIDTH = 10,
  parameter int OE_CYC = `OE_CYCLES,
  parameter int BLANK_CYC = `BLANK_CYCLES,
  parameter int PULSE_CYC = `PULSE_CYCLES,
  parameter int STEP_CYC = `STEP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Analog comparator decision, high when sum is below input
  input wire logic cmp_below,
  // Result pins
  output sar_conv_pkg::result_bus_s result_bus,
  output logic busy,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sar_conv_pkg::*;

  // Counter limits, cut to the 16-bit counters on purpose
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);
  localparam logic [15:0] OE_LAST = 16'(OE_CYC - 1);
  localparam logic [15:0] PULSE_MIN = 16'(PULSE_CYC);
  localparam logic [15:0] BLANK_MIN = 16'(BLANK_CYC);
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [WIDTH-1:0] TOP_BIT = {1'b1, {(WIDTH-1){1'b0}}};

  typedef struct packed {
    conv_state_e state;
    logic [WIDTH-1:0] approximation_register;
    logic [WIDTH-1:0] trial_bit;
    logic [15:0] cnt;
    logic [15:0] high_cnt;
    logic bc_prev;
    logic bipolar;
    result_bus_s out;
    logic [1:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    axi_state_s axi;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic cmp_sync;
  logic bc;
  logic [WIDTH-1:0] trial;
  logic [31:0] rd_word;
  logic [1:0] ev;
  logic do_write;
  // Conversion decodes
  logic bc_fell;
  logic step_end;
  logic pulse_long;
  logic blank_done;
  logic oe_wait;
  logic [15:0] high_cnt_nxt;
  logic [31:0] stat_word;
  // Bus decodes
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;
  logic clr_hit;
  logic rd_ok;

  // Comparator is analog-side, so it crosses in through two flops
  bit_sync bit_sync_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(cmp_below),
    .dout(cmp_sync)
  );

  assign bc = s_q.ctrl[`CTRL_BC_BIT];
  assign trial = s_q.approximation_register | s_q.trial_bit;
  assign do_write = s_q.axi.aw_full && s_q.axi.w_full && !s_q.axi.bvalid;
  // Start line edges and phase lengths
  assign bc_fell = !bc && s_q.bc_prev;
  assign step_end = (s_q.cnt == STEP_LAST);
  assign pulse_long = (s_q.high_cnt >= PULSE_MIN);
  assign blank_done = (s_q.high_cnt >= BLANK_MIN);
  assign oe_wait = (s_q.cnt < OE_LAST);
  // AW, W and AR are taken only while their holding slot is empty; B and R complete on ready
  assign aw_take = s_axi_awvalid && !s_q.axi.aw_full;
  assign w_take = s_axi_wvalid && !s_q.axi.w_full;
  assign ar_take = s_axi_arvalid && !s_q.axi.rvalid;
  assign b_done = s_q.axi.bvalid && s_axi_bready;
  assign r_done = s_q.axi.rvalid && s_axi_rready;
  // Software clear of sticky flags
  assign clr_hit = do_write && (s_q.axi.awaddr == `IRQ_STAT_OFFSET) &&
    s_q.axi.wstrb[0];
  // Only aligned words up to the mask register are decoded
  assign rd_ok = (s_axi_araddr[1:0] == 2'b00) &&
    (s_axi_araddr <= `IRQ_MASK_OFFSET);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CTRL_OFFSET: rd_word[1:0] = s_q.ctrl;
      `STAT_OFFSET: rd_word = stat_word;
      `RESULT_OFFSET: rd_word[WIDTH-1:0] = s_q.out.data;
      `IRQ_STAT_OFFSET: rd_word[1:0] = s_q.irq_stat;
      `IRQ_MASK_OFFSET: rd_word[1:0] = s_q.irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Status bits seen by software
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`STAT_VALID_N_BIT] = s_q.out.result_valid_n;
    stat_word[`STAT_OE_BIT] = s_q.out.data_oe;
    stat_word[`STAT_BUSY_BIT] = busy;
  end

  // Width of the current high phase on the start line, saturating
  always_comb begin
    high_cnt_nxt = 16'h0000;
    if (bc) begin
      high_cnt_nxt = s_q.high_cnt;
      if (s_q.high_cnt != CNT_MAX) begin
        high_cnt_nxt = s_q.high_cnt + 16'h0001;
      end
    end
  end

  always_comb begin
    s_d = s_q;
    ev = 2'b00;
    s_d.bc_prev = bc;
    s_d.high_cnt = high_cnt_nxt;

    case (s_q.state)
      ST_IDLE: begin
        // Standby keeps the bus released and completion high
        s_d.out.data_oe = 1'b0; // R1
        s_d.out.result_valid_n = 1'b1; // R1
        if (bc_fell) begin
          s_d.state = ST_CONV; // R2
          s_d.approximation_register = '0;
          s_d.trial_bit = TOP_BIT;
          s_d.bipolar = s_q.ctrl[`CTRL_BIP_BIT];
          s_d.cnt = 16'h0000;
        end
      end

      ST_CONV: begin
        if (bc) begin
          s_d.state = ST_HOLD; // R6
          ev[`IRQ_ABORT_BIT] = 1'b1;
        end else if (step_end) begin
          s_d.cnt = 16'h0000; // R15
          // One decision per step from the synced comparator
          if (cmp_sync) begin
            s_d.approximation_register = trial; // R13 R16
          end
          s_d.trial_bit = s_q.trial_bit >> 1; // R13
          if (s_q.trial_bit[0]) begin
            s_d.state = ST_DONE;
            s_d.out.result_valid_n = 1'b0; // R3
            ev[`IRQ_DONE_BIT] = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end

      ST_HOLD: begin
        // Aborted: outputs frozen until the line settles
        if (pulse_long) begin
          s_d.state = ST_IDLE; // R7
          s_d.out.data_oe = 1'b0;
          s_d.out.result_valid_n = 1'b1;
        end else if (!bc) begin
          // Short glitch: restart at once, keeping old outputs
          s_d.state = ST_CONV; // R6
          s_d.approximation_register = '0;
          s_d.trial_bit = TOP_BIT;
          s_d.cnt = 16'h0000;
        end
      end

      ST_DONE: begin
        if (oe_wait) begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end else if (!s_q.out.data_oe) begin
          s_d.out.data_oe = 1'b1; // R3
          // Bipolar offset is added on the analog side
          s_d.out.data = s_q.approximation_register; // R8 R9 R14
        end
        if (blank_done) begin
          s_d.state = ST_IDLE; // R4
          s_d.out.data_oe = 1'b0;
          s_d.out.result_valid_n = 1'b1;
        end
      end

      default: s_d.state = ST_IDLE;
    endcase

    // Hardware set wins over software clear
    if (clr_hit) begin
      s_d.irq_stat = s_q.irq_stat & ~s_q.axi.wdata[1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;

    // AXI write channel: address and data accepted in either order
    if (aw_take) begin
      s_d.axi.aw_full = 1'b1;
      s_d.axi.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      s_d.axi.w_full = 1'b1;
      s_d.axi.wdata = s_axi_wdata;
      s_d.axi.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      s_d.axi.aw_full = 1'b0;
      s_d.axi.w_full = 1'b0;
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = `RESP_OKAY;
      case (s_q.axi.awaddr)
        `CTRL_OFFSET: begin
          if (s_q.axi.wstrb[0]) begin
            s_d.ctrl = s_q.axi.wdata[1:0];
          end
        end
        `IRQ_MASK_OFFSET: begin
          if (s_q.axi.wstrb[0]) begin
            s_d.irq_mask = s_q.axi.wdata[1:0];
          end
        end
        `IRQ_STAT_OFFSET: s_d.axi.bresp = `RESP_OKAY;
        `STAT_OFFSET, `RESULT_OFFSET: s_d.axi.bresp = `RESP_OKAY;
        default: s_d.axi.bresp = `RESP_SLVERR;
      endcase
    end
    if (b_done) begin
      s_d.axi.bvalid = 1'b0;
    end

    // AXI read channel
    if (ar_take) begin
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = rd_word;
      s_d.axi.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      s_d.axi.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.ctrl <= `CTRL_RESET;
      s_q.bc_prev <= 1'b1;
      s_q.out.result_valid_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Data pins carry offset-binary or straight code as latched
  always_comb begin
    result_bus = s_q.out;
    if (s_q.bipolar) begin
      result_bus.data = s_q.out.data; // R9
    end
  end

  // Conversion status and interrupt level
  assign busy = (s_q.state == ST_CONV);
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // Ready outputs come straight from the holding slots
  assign s_axi_awready = !s_q.axi.aw_full;
  assign s_axi_wready = !s_q.axi.w_full;
  assign s_axi_bvalid = s_q.axi.bvalid;
  assign s_axi_bresp = s_q.axi.bresp;
  assign s_axi_arready = !s_q.axi.rvalid;
  assign s_axi_rvalid = s_q.axi.rvalid;
  assign s_axi_rdata = s_q.axi.rdata;
  assign s_axi_rresp = s_q.axi.rresp;
endmodule : sar_adc_convert_control

//--- verification/cmp_model.sv
// Comparator stand-in that steers each trial bit towards a target code
module cmp_model #(
  parameter int STEP = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Conversion activity and wanted code
  input wire logic busy,
  input wire logic [9:0] code,
  // Decision
  output logic cmp_below
);
  int cyc_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst || !busy) cyc_q <= 0;
    else cyc_q <= cyc_q + 1;
  end
  // Idle level is inverted so a late sample cannot pass for a decision
  assign cmp_below = busy ? code[9 - (cyc_q / STEP) % 10] : ~code[0];
endmodule : cmp_model

//--- verification/conv_checker.sv
// Timing checks on the converter result pins
module conv_checker #(
  parameter int STEP_CYC = 500,
  parameter int OE_CYC = 62
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Result pins
  input wire sar_conv_pkg::result_bus_s result_bus,
  input wire logic busy
);
  import sar_conv_pkg::*;
  int run_q;
  logic vn;
  logic oe;
  assign vn = result_bus.result_valid_n;
  assign oe = result_bus.data_oe;
  // Busy run length, held after the fall so completion can be judged
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) run_q <= 0;
    else if (busy) run_q <= $rose(busy) ? 1 : run_q + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence oe_on;
    ##[1:OE_CYC] $rose(oe);
  endsequence
  blank_pair_a: assert property (vn |-> !oe)
    else $error("data driven while not ready");
  start_keep_a: assert property ($rose(busy) |-> $stable(result_bus))
    else $error("outputs moved at start");
  no_oe_busy_a: assert property (busy |-> !$rose(oe))
    else $error("data driven mid conversion");
  oe_delay_a: assert property ($fell(vn) |-> oe_on)
    else $error("data enable late");
  done_end_a: assert property ($fell(vn) |-> $fell(busy))
    else $error("ready without conversion end");
  conv_len_a: assert property ($fell(vn) |-> run_q == 10 * STEP_CYC)
    else $error("conversion length wrong");
  release_a: assert property ($fell(oe) |-> $rose(vn))
    else $error("release not paired");
  abort_keep_a: assert property (
    $fell(busy) && vn |-> $stable(result_bus))
    else $error("abort moved outputs");
  hold_a: assert property (
    oe && $past(oe) |-> $stable(result_bus.data))
    else $error("held result changed");
endmodule : conv_checker

bind sar_adc_convert_control conv_checker #(
  .STEP_CYC(STEP_CYC),
  .OE_CYC(OE_CYC)
) conv_checker_inst (
  .sys_clk(sys_clk),
  .rst(rst),
  .result_bus(result_bus),
  .busy(busy)
);

//--- verification/test_sar_adc_convert_control.sv
// Register-level tests of the converter control block
`include "sar_conv_regs.svh"
module test_sar_adc_convert_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_conv_pkg::*;
  localparam int STEP = 8;
  logic sys_clk = 1'b0, rst = 1'b1, cmp_below, busy, irq;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] code = 10'h000;
  logic [9:0] codes [4] = '{10'h2A5, 10'h000, 10'h200, 10'h3FF};
  result_bus_s rb;
  int err_count = 0, checks = 0;
  always #4 sys_clk = ~sys_clk;
  sar_adc_convert_control #(.OE_CYC(2), .BLANK_CYC(3), .PULSE_CYC(4),
    .STEP_CYC(STEP)) sar_adc_convert_control_inst (
    .sys_clk(sys_clk), .rst(rst), .cmp_below(cmp_below), .result_bus(rb),
    .busy(busy), .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre));
  cmp_model #(.STEP(STEP)) cmp_model_inst (.sys_clk(sys_clk), .rst(rst),
    .busy(busy), .code(code), .cmp_below(cmp_below));
  task automatic cmp(input logic [31:0] s, input logic [31:0] e,
    input string what);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    @(posedge sys_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      // Sample handshakes mid-cycle, act right after the edge
      @(negedge sys_clk);
      aw_t = awv && awr;
      w_t = wv && wrd;
      b_t = bv;
      resp = bresp;
      @(posedge sys_clk);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
    end while (b_t !== 1'b1);
    bre <= 1'b0;
    cmp(resp, er, "bresp");
  endtask : wr
  task automatic chk(input logic [4:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic ar_t, r_t;
    logic [1:0] resp;
    logic [31:0] dat;
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_t = arv && arr;
      r_t = rv;
      resp = rresp;
      dat = rdata;
      @(posedge sys_clk);
      if (ar_t) arv <= 1'b0;
    end while (r_t !== 1'b1);
    rre <= 1'b0;
    cmp(resp, er, "rresp");
    if (er == `RESP_OKAY) cmp(dat, e, "rdata");
  endtask : chk
  task automatic conv(input logic [31:0] c);
    wr(`CTRL_OFFSET, c, `RESP_OKAY);
    do @(negedge sys_clk); while (busy !== 1'b1);
    do @(negedge sys_clk); while (busy !== 1'b0);
  endtask : conv
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    chk(`STAT_OFFSET, 32'h1, `RESP_OKAY);
    chk(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    chk(5'h14, 32'h0, `RESP_SLVERR);
    // First code unipolar, then the three bipolar corner codes
    for (int i = 0; i < 4; i++) begin
      code <= codes[i];
      conv({30'h0, i != 0, 1'b0});
      repeat (3) @(posedge sys_clk);
      cmp(rb.data_oe, 1'b1, "oe");
      cmp(rb.result_valid_n, 1'b0, "ready");
      cmp(rb.data, codes[i], "pins");
      repeat (40) @(posedge sys_clk);
      chk(`RESULT_OFFSET, codes[i], `RESP_OKAY);
      chk(`STAT_OFFSET, 32'h2, `RESP_OKAY);
      wr(`CTRL_OFFSET, {30'h0, i != 0, 1'b1}, `RESP_OKAY);
      repeat (6) @(posedge sys_clk);
      chk(`STAT_OFFSET, 32'h1, `RESP_OKAY);
    end
    cmp(irq, 1'b0, "irq");
    chk(`IRQ_STAT_OFFSET, 32'h1, `RESP_OKAY);
    wr(`IRQ_MASK_OFFSET, 32'h3, `RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b1, "irq");
    wr(`IRQ_STAT_OFFSET, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b0, "irq");
    wr(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    cmp(busy, 1'b1, "busy");
    wr(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    chk(`STAT_OFFSET, 32'h1, `RESP_OKAY);
    cmp(irq, 1'b1, "irq");
    repeat (6) @(posedge sys_clk);
    code <= 10'h155;
    conv(32'h0);
    repeat (3) @(posedge sys_clk);
    chk(`RESULT_OFFSET, 32'h155, `RESP_OKAY);
    // Convert-pulse mode: line low, one positive pulse per conversion
    code <= 10'h0AA;
    wr(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    repeat (6) @(posedge sys_clk);
    conv(32'h0);
    repeat (3) @(posedge sys_clk);
    cmp(rb.data, 10'h0AA, "pulse data");
    cmp(rb.data_oe, 1'b1, "pulse oe");
    conclude();
  end
endmodule : test_sar_adc_convert_control
